// ---- logic/scvf_pkg.sv ----
// package: constants for the speech command decoder block
`default_nettype none
package scvf_pkg;
   // ======================================================
   // command opcodes (first byte)
   localparam logic [7:0] OP_AMP_GAIN    = 8'h00;
   localparam logic [7:0] OP_FADE_CFG    = 8'h0C;
   localparam logic [7:0] OP_FLASH_DIR   = 8'h10;
   localparam logic [7:0] OP_WDT_CLEAR   = 8'h14;
   localparam logic [7:0] OP_SLEEP       = 8'h20;
   localparam logic [7:0] OP_WAKE        = 8'h01;
   localparam logic [3:0] OP_PHRASE_HI   = 4'h3;
   // ======================================================
   // field layouts and defaults
   localparam int         GAIN_LSB       = 2;
   localparam int         STEP_LSB       = 1;
   localparam logic [3:0] GAIN_DEFAULT   = 4'h8;
   localparam logic [7:0] UNLOCK_BLOCKED = 8'h69;
   // ======================================================
   // register byte offsets and field bit positions
   localparam logic [7:0] REG_CTRL       = 8'h00;
   localparam logic [7:0] REG_STATUS     = 8'h04;
   localparam logic [7:0] REG_VOLUME     = 8'h08;
   localparam logic [7:0] REG_PHRASE0    = 8'h0C;
   localparam int         RATE_LSB       = 8;
   localparam int         CUR_VOL_LSB    = 8;
   // ======================================================
   // timing
   localparam int         SYS_CLK_HZ     = 25_000_000;
   localparam int         GRP_NS_10K7    = 23_440;
   localparam int         GRP_NS_6K4     = 39_060;
   localparam int         GRP_NS_8K      = 31_250;
   localparam int         GRP_NS_11K     = 22_680;
   localparam int         GRP_NS_12K     = 20_830;
   localparam int         RAMP_NUM       = 264;
   localparam int         RAMP_DEN       = 256;
   localparam int         SLEEP_TIME_US  = 200;
   localparam int         SLEEP_CYCLES   = SLEEP_TIME_US * (SYS_CLK_HZ / 1_000_000);
   typedef enum logic [2:0] {
      RATE_10K7 = 3'h0,
      RATE_6K4  = 3'h1,
      RATE_8K   = 3'h2,
      RATE_11K  = 3'h3,
      RATE_12K  = 3'h4
   } scvf_rate_t;
   typedef enum logic [2:0] {
      ST_OPCODE = 3'b001,
      ST_ARG    = 3'b010,
      ST_DIRECT = 3'b100
   } scvf_state_t;
endpackage : scvf_pkg
`default_nettype wire

// ---- logic/scvf_top.sv ----
// speech command decoder: gain, fade, flash unlock, watchdog clear, sleep, phrase select
`default_nettype none
module scvf_top #(
   parameter int             NUM_CH        = 4,
   parameter int             SLEEP_CYC     = scvf_pkg::SLEEP_CYCLES,
   parameter logic [7:0]     UNLOCK_RESET  = 8'h00
) (
   input  wire logic               i_sys_clk,
   input  wire logic               i_arst_n,
   input  wire logic               i_link_sck,
   input  wire logic               i_link_sdi,
   input  wire logic               i_link_csn,
   input  wire logic [NUM_CH-1:0]  i_channel_busy_n,
   input  wire logic               i_psel,
   input  wire logic               i_penable,
   input  wire logic               i_pwrite,
   input  wire logic [7:0]         i_paddr,
   input  wire logic [31:0]        i_pwdata,
   output logic [31:0]             o_prdata,
   output logic                    o_pready,
   output logic                    o_pslverr,
   output logic [3:0]              o_amp_gain_code,
   output logic                    o_fade_en,
   output logic [2:0]              o_ramp_step_select,
   output logic [6:0]              o_volume,
   output logic                    o_flash_direct,
   output logic                    o_wdt_clear,
   output logic                    o_sleep,
   output logic                    o_osc_stop,
   output logic [NUM_CH-1:0]       o_phrase_load
);
   // ======================================================
   // reset release
   logic [1:0] rst_sync_q;
   logic       rst_n;
   always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
      if (!i_arst_n) rst_sync_q <= 2'h0;
      else rst_sync_q <= {rst_sync_q[0], 1'b1};
   end
   assign rst_n = rst_sync_q[1];

   // ======================================================
   // link pin sampling: three flops, level counts once stages 2 and 3 agree
   logic [2:0] sck_q, sdi_q, csn_q;
   logic       sck_f_q, csn_f_q, sck_rise;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         sck_q   <= 3'h0;
         sdi_q   <= 3'h0;
         csn_q   <= 3'h7;
         sck_f_q <= 1'b0;
         csn_f_q <= 1'b1;
      end else begin
         sck_q <= {sck_q[1:0], i_link_sck};
         sdi_q <= {sdi_q[1:0], i_link_sdi};
         csn_q <= {csn_q[1:0], i_link_csn};
         if (sck_q[1] == sck_q[2]) sck_f_q <= sck_q[2];
         if (csn_q[1] == csn_q[2]) csn_f_q <= csn_q[2];
      end
   end
   assign sck_rise = (sck_q[1] == sck_q[2]) && sck_q[2] && !sck_f_q;

   // ======================================================
   // byte assembly, msb first
   logic [6:0] shift_q;
   logic [2:0] bit_cnt_q;
   logic       byte_vld;
   logic [7:0] byte_val;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         shift_q   <= 7'h00;
         bit_cnt_q <= 3'h0;
      end else if (csn_f_q) begin
         bit_cnt_q <= 3'h0;
      end else if (sck_rise) begin
         shift_q   <= {shift_q[5:0], sdi_q[2]};
         bit_cnt_q <= bit_cnt_q + 3'h1;
      end
   end
   assign byte_vld = !csn_f_q && sck_rise && (bit_cnt_q == 3'h7);
   assign byte_val = {shift_q, sdi_q[2]};

   // ======================================================
   // command decode
   scvf_pkg::scvf_state_t state_q;
   logic [7:0]  op_q;
   logic [7:0]  unlock_stored_q;
   logic [2:0]  rate_q;
   logic [6:0]  target_q;
   logic        sleep_go;
   logic [9:0]  phrase_q [NUM_CH];

   function automatic logic is_two_byte(input logic [7:0] b);
      return (b == scvf_pkg::OP_AMP_GAIN) || (b == scvf_pkg::OP_FADE_CFG) ||
             (b == scvf_pkg::OP_FLASH_DIR) || (b[7:4] == scvf_pkg::OP_PHRASE_HI);
   endfunction : is_two_byte

   // power-down is refused while any channel is busy
   assign sleep_go = byte_vld && (state_q == scvf_pkg::ST_OPCODE) && !o_sleep &&
                     (byte_val == scvf_pkg::OP_SLEEP) && (&i_channel_busy_n);

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         state_q        <= scvf_pkg::ST_OPCODE;
         op_q           <= 8'h00;
         o_flash_direct <= 1'b0;
      end else begin
         case (state_q)
            scvf_pkg::ST_OPCODE: begin
               if (byte_vld && !o_sleep && is_two_byte(byte_val)) begin
                  op_q    <= byte_val;
                  state_q <= scvf_pkg::ST_ARG;
               end
            end
            scvf_pkg::ST_ARG: begin
               if (byte_vld) begin
                  state_q <= scvf_pkg::ST_OPCODE;
                  if (op_q == scvf_pkg::OP_FLASH_DIR &&
                      unlock_stored_q != scvf_pkg::UNLOCK_BLOCKED &&
                      byte_val == unlock_stored_q) begin
                     state_q        <= scvf_pkg::ST_DIRECT;
                     o_flash_direct <= 1'b1;
                  end
               end
            end
            // serial traffic now belongs to the flash; only reset leaves
            scvf_pkg::ST_DIRECT: state_q <= scvf_pkg::ST_DIRECT;
            default: state_q <= scvf_pkg::ST_OPCODE;
         endcase
      end
   end

   logic arg_done;
   assign arg_done = byte_vld && (state_q == scvf_pkg::ST_ARG);

   // gain and fade settings take effect regardless of channel readiness
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_amp_gain_code    <= scvf_pkg::GAIN_DEFAULT;
         o_fade_en          <= 1'b0;
         o_ramp_step_select <= 3'h0;
      end else if (sleep_go) begin
         o_amp_gain_code    <= scvf_pkg::GAIN_DEFAULT;
         o_fade_en          <= 1'b0;
         o_ramp_step_select <= 3'h0;
      end else if (arg_done && op_q == scvf_pkg::OP_AMP_GAIN) begin
         o_amp_gain_code <= byte_val[scvf_pkg::GAIN_LSB +: 4];
      end else if (arg_done && op_q == scvf_pkg::OP_FADE_CFG) begin
         o_fade_en          <= byte_val[0];
         o_ramp_step_select <= byte_val[scvf_pkg::STEP_LSB +: 3];
      end
   end

   // phrase is only stored; playback waits for a later start command
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_phrase_load <= '0;
         for (int c = 0; c < NUM_CH; c++) phrase_q[c] <= 10'h000;
      end else begin
         o_phrase_load <= '0;
         if (sleep_go) begin
            for (int c = 0; c < NUM_CH; c++) phrase_q[c] <= 10'h000;
         end else if (arg_done && op_q[7:4] == scvf_pkg::OP_PHRASE_HI) begin
            phrase_q[op_q[1:0]]      <= {op_q[3:2], byte_val};
            o_phrase_load[op_q[1:0]] <= 1'b1;
         end
      end
   end

   // ======================================================
   // watchdog clear, sleep and oscillator stop
   logic [$clog2(SLEEP_CYC+1)-1:0] sleep_cnt_q;
   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_wdt_clear <= 1'b0;
         o_sleep     <= 1'b0;
         o_osc_stop  <= 1'b0;
         sleep_cnt_q <= '0;
      end else begin
         o_wdt_clear <= byte_vld && !o_sleep && state_q == scvf_pkg::ST_OPCODE &&
                        byte_val == scvf_pkg::OP_WDT_CLEAR;
         if (sleep_go) begin
            o_sleep     <= 1'b1;
            sleep_cnt_q <= '0;
         end else if (o_sleep && byte_vld && byte_val == scvf_pkg::OP_WAKE) begin
            o_sleep    <= 1'b0;
            o_osc_stop <= 1'b0;
         end else if (o_sleep && !o_osc_stop) begin
            // the clock must keep running until processing is over
            if (sleep_cnt_q == ($bits(sleep_cnt_q))'(SLEEP_CYC - 1)) o_osc_stop <= 1'b1;
            else sleep_cnt_q <= sleep_cnt_q + ($bits(sleep_cnt_q))'(1);
         end
      end
   end

   // ======================================================
   // volume ramp
   function automatic logic [11:0] grp_cycles(input logic [2:0] r);
      int ns;
      case (r)
         scvf_pkg::RATE_6K4: ns = scvf_pkg::GRP_NS_6K4;
         scvf_pkg::RATE_8K:  ns = scvf_pkg::GRP_NS_8K;
         scvf_pkg::RATE_11K: ns = scvf_pkg::GRP_NS_11K;
         scvf_pkg::RATE_12K: ns = scvf_pkg::GRP_NS_12K;
         default:            ns = scvf_pkg::GRP_NS_10K7;
      endcase
      return 12'((ns * (scvf_pkg::SYS_CLK_HZ / 1_000_000)) / 1000);
   endfunction : grp_cycles

   logic [11:0] grp_cnt_q;
   logic [7:0]  unit_cnt_q;
   logic [7:0]  unit_len;
   logic        grp_tick;
   // ceil(264 * 2^s / 256) periods per volume code unit
   assign unit_len = 8'((scvf_pkg::RAMP_NUM * (32'd1 << o_ramp_step_select)
                     + scvf_pkg::RAMP_DEN - 1) / scvf_pkg::RAMP_DEN);
   // a rate change can leave the count past the new period end; >= ends it at once
   // instead of letting it run round the full counter range
   assign grp_tick = (grp_cnt_q >= grp_cycles(rate_q) - 12'h001);

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         grp_cnt_q  <= 12'h000;
         unit_cnt_q <= 8'h00;
         o_volume   <= 7'h00;
      end else begin
         grp_cnt_q <= grp_tick ? 12'h000 : grp_cnt_q + 12'h001;
         if (!o_fade_en) begin
            o_volume   <= target_q;
            unit_cnt_q <= 8'h00;
         end else if (o_volume == target_q) begin
            unit_cnt_q <= 8'h00;
         end else if (grp_tick) begin
            if (unit_cnt_q >= unit_len - 8'h01) begin
               unit_cnt_q <= 8'h00;
               o_volume   <= (o_volume < target_q) ? o_volume + 7'h01
                                                   : o_volume - 7'h01;
            end else begin
               unit_cnt_q <= unit_cnt_q + 8'h01;
            end
         end
      end
   end

   // ======================================================
   // apb slave: one wait-free access, answer registered
   logic access, wr;
   logic [31:0] rd_mux;
   logic        hit;
   assign access = i_psel && i_penable && o_pready;
   assign wr     = access && i_pwrite;

   always_comb begin
      rd_mux = 32'h0000_0000;
      hit    = 1'b1;
      if (i_paddr == scvf_pkg::REG_CTRL)
         rd_mux = {21'h0, rate_q, unlock_stored_q};
      else if (i_paddr == scvf_pkg::REG_STATUS)
         rd_mux = {20'h0, o_osc_stop, o_sleep, o_flash_direct, o_fade_en,
                   o_ramp_step_select, o_amp_gain_code, o_wdt_clear};
      else if (i_paddr == scvf_pkg::REG_VOLUME)
         rd_mux = {17'h0, o_volume, 1'b0, target_q};
      else if (i_paddr >= scvf_pkg::REG_PHRASE0 && i_paddr[1:0] == 2'h0 &&
               i_paddr < scvf_pkg::REG_PHRASE0 + 8'(4 * NUM_CH))
         rd_mux = {22'h0, phrase_q[2'((i_paddr - scvf_pkg::REG_PHRASE0) >> 2)]};
      else
         hit = 1'b0;
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         o_pready  <= 1'b0;
         o_prdata  <= 32'h0000_0000;
         o_pslverr <= 1'b0;
      end else begin
         o_pready  <= i_psel && !i_penable;
         o_prdata  <= (i_psel && !i_penable && !i_pwrite) ? rd_mux : 32'h0000_0000;
         o_pslverr <= i_psel && !i_penable && !hit;
      end
   end

   always_ff @(posedge i_sys_clk or negedge rst_n) begin
      if (!rst_n) begin
         unlock_stored_q <= UNLOCK_RESET;
         rate_q          <= scvf_pkg::RATE_10K7;
         target_q        <= 7'h00;
      end else if (wr && i_paddr == scvf_pkg::REG_CTRL) begin
         unlock_stored_q <= i_pwdata[7:0];
         rate_q          <= i_pwdata[scvf_pkg::RATE_LSB +: 3];
      end else if (wr && i_paddr == scvf_pkg::REG_VOLUME) begin
         target_q <= i_pwdata[6:0];
      end
   end
endmodule : scvf_top
`default_nettype wire

// ---- verification/scvf_top_sva.sv ----
// checker: port-level assertions for the speech command decoder
`default_nettype none
module scvf_top_chk #(
   parameter int NUM_CH    = 4,
   parameter int SLEEP_CYC = 20
) (
   input wire logic              i_sys_clk,
   input wire logic              i_arst_n,
   input wire logic [NUM_CH-1:0] i_channel_busy_n,
   input wire logic [3:0]        o_amp_gain_code,
   input wire logic              o_fade_en,
   input wire logic [2:0]        o_ramp_step_select,
   input wire logic [6:0]        o_volume,
   input wire logic              o_flash_direct,
   input wire logic              o_wdt_clear,
   input wire logic              o_sleep,
   input wire logic              o_osc_stop,
   input wire logic [NUM_CH-1:0] o_phrase_load
);
   timeunit 1ns;
   timeprecision 1ps;
   // slack for the byte-to-sleep pipeline on either side of the count
   localparam int OSC_LO = SLEEP_CYC - 4;
   localparam int OSC_HI = SLEEP_CYC + 4;
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (!i_arst_n);
   // ==========
   // assertions
   a_reset_defaults: assert property ($rose(i_arst_n) |-> o_amp_gain_code == 4'h8
      && !o_fade_en && !o_flash_direct && !o_sleep) else $error("not at defaults after reset");
   a_direct_sticky: assert property (o_flash_direct |=> o_flash_direct)
      else $error("direct mode left without reset");
   a_direct_quiet: assert property (o_flash_direct && $past(o_flash_direct) |->
      !o_wdt_clear && o_phrase_load == '0) else $error("command acted on in direct mode");
   a_wdt_pulse: assert property (o_wdt_clear |=> !o_wdt_clear)
      else $error("watchdog clear longer than one cycle");
   a_sleep_busy: assert property ($rose(o_sleep) |-> &$past(i_channel_busy_n))
      else $error("sleep taken while a channel busy");
   a_sleep_defaults: assert property ($rose(o_sleep) |-> ##[0:2] (o_amp_gain_code == 4'h8
      && !o_fade_en && o_ramp_step_select == 3'h0)) else $error("settings kept over sleep");
   a_osc_delay: assert property ($rose(o_sleep) |-> ##[OSC_LO:OSC_HI] $rose(o_osc_stop))
      else $error("oscillator stop off its delay");
   a_phrase_onehot: assert property (o_phrase_load != '0 |-> $onehot(o_phrase_load)
      ##1 o_phrase_load == '0) else $error("phrase load not a single one-cycle pulse");
   a_fade_step: assert property (o_fade_en ##1 o_fade_en |-> $stable(o_volume)
      || o_volume == $past(o_volume) + 7'h01 || o_volume == $past(o_volume) - 7'h01)
      else $error("volume jumped while fading");
endmodule : scvf_top_chk
bind scvf_top scvf_top_chk #(.NUM_CH(NUM_CH), .SLEEP_CYC(SLEEP_CYC)) u_chk (
   .i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_channel_busy_n(i_channel_busy_n),
   .o_amp_gain_code(o_amp_gain_code), .o_fade_en(o_fade_en), .o_volume(o_volume),
   .o_ramp_step_select(o_ramp_step_select), .o_flash_direct(o_flash_direct),
   .o_wdt_clear(o_wdt_clear), .o_sleep(o_sleep), .o_osc_stop(o_osc_stop),
   .o_phrase_load(o_phrase_load));
`default_nettype wire

// ---- verification/scvf_host_model.sv ----
// host-side model: shifts command bytes onto the serial link, msb first
`default_nettype none
module scvf_host_model (
   output logic o_sck,
   output logic o_sdi,
   output logic o_csn
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      o_sck = 1'b0;
      o_sdi = 1'b1;
      o_csn = 1'b1;
   end
   // ==========
   // framing: clock rests low between frames; idle data flips so no stale bit looks valid
   task automatic shift(input logic b);
      o_sdi = b;
      #160 o_sck = 1'b1;
      #160 o_sck = 1'b0;
   endtask : shift
   task automatic idle();
      #160 o_csn = 1'b1;
      o_sdi = ~o_sdi;
      #160;
   endtask : idle
   task automatic send8(input logic [7:0] b);
      #7 o_csn = 1'b0;
      for (int i = 7; i >= 0; i--) shift(b[i]);
      idle();
   endtask : send8
   task automatic send16(input logic [15:0] w);
      #7 o_csn = 1'b0;
      for (int i = 15; i >= 0; i--) shift(w[i]);
      idle();
   endtask : send16
endmodule : scvf_host_model
`default_nettype wire

// ---- verification/scvf_top_tb.sv ----
// testbench: drives the command decoder over the link and the register bus
`default_nettype none
module scvf_top_tb;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int SLP = 40;
   logic        clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [3:0]  busy_n = 4'hF;
   logic [7:0]  paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rng = 32'd70437;
   logic        pready, pslverr, wdt, fdir;
   logic [6:0]  vol;
   logic [3:0]  load;
   wire         sck, sdi, csn;
   logic [34:0] q[$];
   int          err_total = 0, checks = 0, cyc = 0;
   int          grp_ns[5] = '{scvf_pkg::GRP_NS_10K7, scvf_pkg::GRP_NS_6K4, scvf_pkg::GRP_NS_8K,
                              scvf_pkg::GRP_NS_11K, scvf_pkg::GRP_NS_12K};
   scvf_host_model host (.o_sck(sck), .o_sdi(sdi), .o_csn(csn));
   scvf_top #(.SLEEP_CYC(SLP)) dut (
      .i_sys_clk(clk), .i_arst_n(arst_n), .i_link_sck(sck), .i_link_sdi(sdi),
      .i_link_csn(csn), .i_channel_busy_n(busy_n), .i_psel(psel), .i_penable(penable),
      .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
      .o_pready(pready), .o_pslverr(pslverr), .o_amp_gain_code(), .o_fade_en(),
      .o_ramp_step_select(), .o_volume(vol), .o_flash_direct(fdir), .o_wdt_clear(wdt),
      .o_sleep(), .o_osc_stop(), .o_phrase_load(load));
   always #20 clk = ~clk;
   // ==========
   // helpers
   function automatic logic [31:0] rnd();
      rng ^= rng << 13;
      rng ^= rng >> 17;
      rng ^= rng << 5;
      return rng;
   endfunction : rnd
   function automatic logic [32:0] stat(logic [3:0] g, logic [2:0] s, logic f, sl, o);
      return {21'h0, o, sl, 1'b0, f, s, g, 1'b0};
   endfunction : stat
   task automatic note_bad(input string msg);
      err_total++;
      $display("unexpected at %0t: %s", $time, msg);
   endtask : note_bad
   task automatic cmp_note(input logic [34:0] exp, input logic [34:0] got);
      checks++;
      if (got !== exp) note_bad($sformatf("result %h, wanted %h", got, exp));
   endtask : cmp_note
   task automatic cmp_level(input logic ok, input string what);
      checks++;
      if (ok !== 1'b1) note_bad(what);
   endtask : cmp_level
   task automatic tally_and_finish();
      if (q.size() != 0) note_bad("noted result never came");
      $display("errors %0d, checks %0d", err_total, checks);
      if (err_total == 0 && checks > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : tally_and_finish
   // the master holds every request field until pready is seen at an edge
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      int n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && n < 50) begin
         n++;
         @(posedge clk);
      end
      if (n == 50) note_bad("bus never answered");
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic expect_rd(input logic [7:0] a, input logic [32:0] v);
      q.push_back({2'd0, v});
      apb(1'b0, a, 32'h0);
   endtask : expect_rd
   // ==========
   // result watcher: every read answer or pulse must match the oldest note
   task automatic take(input logic [1:0] k, input logic [32:0] v);
      if (q.size() == 0) note_bad("result with no note");
      else cmp_note(q.pop_front(), {k, v});
   endtask : take
   always @(posedge clk) begin
      cyc++;
      if (psel && penable && !pwrite && pready === 1'b1) take(2'd0, {pslverr, prdata});
      if (arst_n && wdt !== 1'b0) take(2'd1, 33'h1);
      if (arst_n && load !== 4'h0) take(2'd2, {29'h0, load});
      if (cyc == 60000) begin
         note_bad("run too long");
         tally_and_finish();
      end
   end
   // ==========
   // scenarios
   initial begin
      logic [3:0] g;
      logic [9:0] p;
      logic [7:0] u;
      int         t, per, t_exp;
      repeat (16) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      expect_rd(scvf_pkg::REG_STATUS, stat(4'h8, 3'h0, 1'b0, 1'b0, 1'b0));
      expect_rd(8'h40, {1'b1, 32'h0});
      for (int i = 0; i < 5; i++) begin
         g = (i == 4) ? 4'h0 : 4'(rnd() % 13 + 3); // codes 1 and 2 are never sent
         busy_n <= 4'(rnd());
         host.send16({scvf_pkg::OP_AMP_GAIN, 2'b00, g, 2'b00});
         expect_rd(scvf_pkg::REG_STATUS, stat(g, 3'h0, 1'b0, 1'b0, 1'b0));
      end
      q.push_back({2'd1, 33'h1});
      host.send8(scvf_pkg::OP_WDT_CLEAR);
      for (int ch = 0; ch < 4; ch++) begin
         p = 10'(rnd());
         q.push_back({2'd2, 29'h0, 4'(4'h1 << ch)});
         host.send16({scvf_pkg::OP_PHRASE_HI, p[9:8], 2'(ch), p[7:0]}); // busy_n left random
         expect_rd(8'(scvf_pkg::REG_PHRASE0 + 4 * ch), {23'h0, p});
      end
      for (int r = 0; r < 5; r++) begin
         host.send16({scvf_pkg::OP_FADE_CFG, 4'h0, 3'(r), 1'b1});
         expect_rd(scvf_pkg::REG_STATUS, stat(g, 3'(r), 1'b1, 1'b0, 1'b0));
         apb(1'b1, scvf_pkg::REG_CTRL, {21'h0, 3'(r), 8'h00});
         apb(1'b1, scvf_pkg::REG_VOLUME, {31'h0, ~r[0]});
         t = 0;
         while (vol !== {6'h0, ~r[0]} && t < 20000) begin
            @(posedge clk);
            t++;
         end
         per = grp_ns[r] * 25 / 1000;
         t_exp = ((264 << r) + 255) / 256 * per;
         cmp_level(t >= t_exp - per && t <= t_exp + per, "fade time");
      end
      host.send16({scvf_pkg::OP_FADE_CFG, 8'h00});
      apb(1'b1, scvf_pkg::REG_VOLUME, 32'h0000_0055);
      expect_rd(scvf_pkg::REG_VOLUME, 33'h0_0000_5555);
      host.send8(scvf_pkg::OP_AMP_GAIN);
      host.send8(8'h3C);
      host.send16({scvf_pkg::OP_FADE_CFG, 8'h0B});
      @(posedge clk);
      busy_n <= 4'(rnd()) & ~(4'h1 << (rnd() % 4));
      host.send8(scvf_pkg::OP_SLEEP);
      expect_rd(scvf_pkg::REG_STATUS, stat(4'hF, 3'h5, 1'b1, 1'b0, 1'b0));
      busy_n <= 4'hF;
      host.send8(scvf_pkg::OP_SLEEP);
      expect_rd(scvf_pkg::REG_STATUS, stat(4'h8, 3'h0, 1'b0, 1'b1, 1'b0));
      repeat (SLP + 8) @(posedge clk);
      expect_rd(scvf_pkg::REG_STATUS, stat(4'h8, 3'h0, 1'b0, 1'b1, 1'b1));
      host.send8(scvf_pkg::OP_WDT_CLEAR);
      host.send8(scvf_pkg::OP_WAKE);
      q.push_back({2'd1, 33'h1});
      host.send8(scvf_pkg::OP_WDT_CLEAR);
      u = 8'(rnd());
      if (u == 8'h69) u = 8'h6A;
      apb(1'b1, scvf_pkg::REG_CTRL, 32'h0000_0069);
      host.send16({scvf_pkg::OP_FLASH_DIR, 8'h69}); // sent after wake
      cmp_level(fdir === 1'b0, "blocked code unlocked");
      apb(1'b1, scvf_pkg::REG_CTRL, {24'h0, u});
      host.send16({scvf_pkg::OP_FLASH_DIR, u ^ 8'h01});
      cmp_level(fdir === 1'b0, "wrong code unlocked");
      host.send16({scvf_pkg::OP_FLASH_DIR, u});
      cmp_level(fdir === 1'b1, "matching code refused");
      host.send8(scvf_pkg::OP_WDT_CLEAR);
      host.send8(scvf_pkg::OP_SLEEP);
      cmp_level(fdir === 1'b1, "direct mode left by command");
      @(posedge clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge clk);
      arst_n <= 1'b1;
      repeat (4) @(posedge clk);
      cmp_level(fdir === 1'b0, "direct mode kept over reset");
      expect_rd(scvf_pkg::REG_STATUS, stat(4'h8, 3'h0, 1'b0, 1'b0, 1'b0));
      repeat (4) @(posedge clk);
      tally_and_finish();
   end
endmodule : scvf_top_tb
`default_nettype wire
